//--- src/pmtr_pkg.sv
// Shared constants and types of the program memory table read block.
// Assumes one 25 MHz clock and a core that counts four clocks per instruction cycle.
package pmtr_pkg;

  // Code store geometry
  localparam int WORDS = 2048;
  localparam int ADDR_W = 11;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int PAGE_W = 8;

  // Reset vector loaded into the program counter
  localparam logic [10:0] RESET_VECTOR = 11'h000;

  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CLKS_PER_ICYCLE = 4;
  localparam int TBL_ICYCLES = 2;
  localparam int TBL_CLKS = CLKS_PER_ICYCLE * TBL_ICYCLES;
  // Busy count loaded at start: start clock, read clock and final write clock come on top
  localparam logic [3:0] TBL_LOAD = 4'(TBL_CLKS - 3);

  // Serial programming frame: command bit, word address, data word
  localparam int PROG_FRAME_BITS = 28;
  localparam logic [4:0] PROG_ADDR_LAST = 5'h0B;
  localparam logic [4:0] PROG_FIRST_OUT = 5'h0C;
  localparam logic [4:0] PROG_LAST_BIT = 5'h1B;
  localparam logic PROG_CMD_WRITE = 1'b1;

  // Table read sequencer states
  typedef enum logic [0:0] {
    TBL_IDLE = 1'b0,
    TBL_BUSY = 1'b1
  } pmtr_tbl_state_type;

  // Table read request from the core
  typedef struct packed {
    logic last_page;
    logic [7:0] dest;
  } pmtr_tbl_req_type;

  // Write of the low table byte into data memory
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } pmtr_dest_wr_type;

endpackage

//--- src/pmtr_code_store.sv
// Code store array with one shared port and a registered read word.
// Assumes the caller never reads and writes in the same cycle.
`timescale 1ns/10ps
module pmtr_code_store #(
  parameter int ADDR_W = pmtr_pkg::ADDR_W,
  parameter int WORD_W = pmtr_pkg::WORD_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic re_in,
  input wire logic we_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [WORD_W-1:0] wdata_in,
  output logic [WORD_W-1:0] rdata_out
);

  logic [WORD_W-1:0] mem_q [0:(1 << ADDR_W)-1];
  logic [WORD_W-1:0] rdata_q;

  // Array write
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[addr_in] <= wdata_in;
    end
  end

  // Registered read word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= '0;
    end else if (re_in) begin
      rdata_q <= mem_q[addr_in];
    end
  end

  assign rdata_out = rdata_q;

endmodule

//--- src/pmtr_top.sv
// Program memory read path: fetch port, table read unit, serial programming and debug pins.
// Assumes synchronous pin inputs and a core that keeps table pointers on its own side.
// Functional notes
// RULE_01 - The code store holds 2K words of 16 bits and serves both fetch by PC and table reads.
// RULE_02 - After any reset the program counter starts at word address 000H.
// RULE_03 - A table read can reach every word of the code store.
// RULE_04 - The table address is the high pointer concatenated with the low pointer.
// RULE_05 - A full-pointer table read fetches the word both pointer registers point to.
// RULE_06 - The low byte of the fetched word is written to the data register named by the operand.
// RULE_07 - The high part of the fetched word overwrites the table-high latch.
// RULE_08 - Latch bits with no stored bit behind them read as zero.
// RULE_09 - Software cannot write the table-high latch; only table reads change it.
// RULE_10 - Every table read takes two instruction cycles and finishes its writes inside them.
// RULE_11 - Software should avoid table reads in both main code and handlers, or mask interrupts.
// RULE_12 - Programming moves code both ways over one serial data pin clocked by the programmer.
// RULE_13 - On the emulation variant the shared functions of the debug pins are cut off.
// RULE_14 - The last-page table read uses the final 256-word page with the low pointer.
// RULE_15 - The high pointer supplies the top three address bits; its other bits are ignored.
`timescale 1ns/10ps
module pmtr_top #(
  parameter int ADDR_W = pmtr_pkg::ADDR_W,
  parameter int WORD_W = pmtr_pkg::WORD_W,
  parameter bit EV_VARIANT = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pc_load_in,
  input wire logic [ADDR_W-1:0] pc_target_in,
  input wire logic fetch_req_in,
  output logic fetch_ready_out,
  output logic [ADDR_W-1:0] pc_out,
  output logic instr_valid_out,
  output logic [WORD_W-1:0] instr_out,
  input wire logic [7:0] tblp_in,
  input wire logic [7:0] tbhp_in,
  input wire logic tbl_start_in,
  input wire pmtr_pkg::pmtr_tbl_req_type tbl_req_in,
  output logic tbl_ready_out,
  output logic tbl_busy_out,
  output logic dest_wr_valid_out,
  output pmtr_pkg::pmtr_dest_wr_type dest_wr_out,
  output logic [7:0] table_high_latch_out,
  input wire logic prog_mode_in,
  input wire logic prog_serial_clock_pin_in,
  input wire logic prog_serial_data_pin_in,
  output logic prog_serial_data_pin_out,
  output logic prog_serial_data_pin_oe_n_out,
  input wire logic debug_serial_clock_pin_in,
  input wire logic debug_serial_data_pin_in,
  output logic debug_serial_data_pin_out,
  output logic debug_serial_data_pin_oe_n_out,
  input wire logic dbg_tx_in,
  input wire logic dbg_tx_en_in,
  output logic dbg_rx_out,
  output logic dbg_clk_out,
  input wire logic func_data_in,
  input wire logic func_oe_n_in,
  output logic func_data_view_out,
  output logic func_clk_view_out
);

  // Parameter sanity
  // The serial frame counters fix the address width, and with it the word width
  if (WORD_W < 9 || WORD_W > 16 || ADDR_W <= 8 || ADDR_W > 16 ||
      ADDR_W != int'(pmtr_pkg::PROG_ADDR_LAST) ||
      ADDR_W + WORD_W + 1 != pmtr_pkg::PROG_FRAME_BITS) begin : g_bad_params
    $error("pmtr_top: unsupported ADDR_W or WORD_W");
  end

  // Table word address: high pointer over low pointer, or the last page
  function automatic logic [ADDR_W-1:0] tbl_addr(input logic last, input logic [7:0] hi,
                                                 input logic [7:0] lo);
    logic [ADDR_W-1:0] a;
    a = '1;
    a[7:0] = lo;
    if (!last) begin
      a[ADDR_W-1:8] = hi[ADDR_W-9:0];
    end
    return a;
  endfunction

  pmtr_pkg::pmtr_tbl_state_type state_q;
  logic [3:0] tcnt_q;
  logic [ADDR_W-1:0] pc_q;
  pmtr_pkg::pmtr_tbl_req_type req_q;
  logic [WORD_W-1:0] word_q;
  logic rd_tbl_q;
  logic rd_fetch_q;
  logic dest_valid_q;
  pmtr_pkg::pmtr_dest_wr_type dest_q;
  logic [7:0] latch_q;
  logic pclk_q;
  logic [4:0] pcnt_q;
  logic [pmtr_pkg::PROG_FRAME_BITS-1:0] psr_q;
  logic prog_rd_go_q;
  logic prog_wr_go_q;
  logic prog_rd_dly_q;
  logic pread_q;
  logic [WORD_W-1:0] pout_q;
  logic dbg_out_q;
  logic dbg_oe_n_q;
  logic dbg_rx_q;
  logic dbg_clk_q;
  logic fview_q;
  logic fclk_q;
  logic tbl_go;
  logic fetch_go;
  logic finish;
  logic prise;
  logic pfall;
  logic mem_re;
  logic mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_rdata;
  logic [7:0] rd_low_w;
  logic [7:0] rd_high_w;

  // Port arbitration: programming owns the store, then table start, then fetch
  assign tbl_ready_out = (state_q == pmtr_pkg::TBL_IDLE) && !prog_mode_in;
  assign tbl_go = tbl_start_in && tbl_ready_out;
  assign fetch_ready_out = !prog_mode_in && !tbl_go;
  assign fetch_go = fetch_req_in && fetch_ready_out;
  assign finish = (state_q == pmtr_pkg::TBL_BUSY) && (tcnt_q == 4'h0);
  assign mem_we = prog_wr_go_q && prog_mode_in && (psr_q[27] == pmtr_pkg::PROG_CMD_WRITE);
  assign mem_re = (prog_rd_go_q && prog_mode_in) || tbl_go || fetch_go;

  // Address select; table reads may point at any word
  always_comb begin
    if (prog_mode_in) begin
      mem_addr = prog_wr_go_q ? psr_q[26:16] : psr_q[10:0];
    end else if (tbl_go) begin
      mem_addr = tbl_addr(tbl_req_in.last_page, tbhp_in, tblp_in); // RULE_03 RULE_04 RULE_14 RULE_15
    end else begin
      mem_addr = pc_q;
    end
  end

  // One store for code and table data
  pmtr_code_store #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) u_store ( // RULE_01
    .clk_in(clk_in),
    .rst_in(rst_in),
    .re_in(mem_re),
    .we_in(mem_we),
    .addr_in(mem_addr),
    .wdata_in(psr_q[15:0]),
    .rdata_out(mem_rdata)
  );

  assign rd_low_w = mem_rdata[7:0];
  assign rd_high_w = 8'(mem_rdata >> 8); // RULE_08

  // Program counter: reset vector, load, step per fetch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pc_q <= pmtr_pkg::RESET_VECTOR; // RULE_02
    end else if (pc_load_in) begin
      pc_q <= pc_target_in;
    end else if (fetch_go) begin
      pc_q <= pc_q + 1'b1;
    end
  end

  // Fetch answer marker
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_fetch_q <= 1'b0;
    end else begin
      rd_fetch_q <= fetch_go;
    end
  end

  // Table read sequencer, two instruction cycles from start to writes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= pmtr_pkg::TBL_IDLE;
      tcnt_q <= 4'h0;
    end else begin
      case (state_q)
        pmtr_pkg::TBL_IDLE: begin
          if (tbl_go) begin
            state_q <= pmtr_pkg::TBL_BUSY;
            tcnt_q <= pmtr_pkg::TBL_LOAD; // RULE_10
          end
        end
        pmtr_pkg::TBL_BUSY: begin
          if (tcnt_q == 4'h0) begin
            state_q <= pmtr_pkg::TBL_IDLE;
          end else begin
            tcnt_q <= tcnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= pmtr_pkg::TBL_IDLE;
        end
      endcase
    end
  end

  // Request and fetched word capture
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_q <= '0;
      rd_tbl_q <= 1'b0;
      word_q <= '0;
    end else begin
      rd_tbl_q <= tbl_go;
      if (tbl_go) begin
        req_q <= tbl_req_in;
      end
      if (rd_tbl_q) begin
        word_q <= mem_rdata; // RULE_05
      end
    end
  end

  // Destination write and latch; no software path reaches the latch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dest_valid_q <= 1'b0;
      dest_q <= '0;
      latch_q <= 8'h00;
    end else begin
      dest_valid_q <= finish;
      if (finish) begin
        dest_q.addr <= req_q.dest; // RULE_06
        dest_q.data <= word_q[7:0]; // RULE_06
        latch_q <= 8'(word_q >> 8); // RULE_07 RULE_08 RULE_09
      end
    end
  end

  // Serial programming: shift command, address and data on rising programmer clock
  assign prise = prog_mode_in && prog_serial_clock_pin_in && !pclk_q;
  assign pfall = prog_mode_in && !prog_serial_clock_pin_in && pclk_q;

  always_ff @(posedge clk_in) begin
    if (rst_in || !prog_mode_in) begin
      pclk_q <= 1'b0;
      pcnt_q <= 5'h00;
      psr_q <= '0;
      prog_rd_go_q <= 1'b0;
      prog_wr_go_q <= 1'b0;
    end else begin
      pclk_q <= prog_serial_clock_pin_in;
      prog_rd_go_q <= prise && (pcnt_q == pmtr_pkg::PROG_ADDR_LAST) && !psr_q[10]; // RULE_12
      prog_wr_go_q <= prise && (pcnt_q == pmtr_pkg::PROG_LAST_BIT); // RULE_12
      if (prise) begin
        psr_q <= {psr_q[26:0], prog_serial_data_pin_in};
        pcnt_q <= (pcnt_q == pmtr_pkg::PROG_LAST_BIT) ? 5'h00 : pcnt_q + 5'h01;
      end
    end
  end

  // Read-back: word loaded after address, shifted out MSB first on falling clock
  always_ff @(posedge clk_in) begin
    if (rst_in || !prog_mode_in) begin
      prog_rd_dly_q <= 1'b0;
      pread_q <= 1'b0;
      pout_q <= '0;
    end else begin
      prog_rd_dly_q <= prog_rd_go_q;
      if (prog_rd_go_q) begin
        pread_q <= 1'b1;
      end else if (prise && pcnt_q == pmtr_pkg::PROG_LAST_BIT) begin
        pread_q <= 1'b0;
      end
      if (prog_rd_dly_q) begin
        pout_q <= mem_rdata; // RULE_12
      end else if (pfall && pcnt_q > pmtr_pkg::PROG_FIRST_OUT) begin
        pout_q <= {pout_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  assign prog_serial_data_pin_out = pout_q[WORD_W-1];
  assign prog_serial_data_pin_oe_n_out = !(pread_q && pcnt_q >= pmtr_pkg::PROG_FIRST_OUT);

  // Debug pins: the emulation variant gives them to the debug link only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dbg_out_q <= 1'b0;
      dbg_oe_n_q <= 1'b1;
      dbg_rx_q <= 1'b0;
      dbg_clk_q <= 1'b0;
      fview_q <= 1'b0;
      fclk_q <= 1'b0;
    end else begin
      dbg_out_q <= EV_VARIANT ? dbg_tx_in : func_data_in; // RULE_13
      dbg_oe_n_q <= EV_VARIANT ? !dbg_tx_en_in : func_oe_n_in; // RULE_13
      dbg_rx_q <= EV_VARIANT && debug_serial_data_pin_in;
      dbg_clk_q <= EV_VARIANT && debug_serial_clock_pin_in;
      fview_q <= !EV_VARIANT && debug_serial_data_pin_in; // RULE_13
      fclk_q <= !EV_VARIANT && debug_serial_clock_pin_in; // RULE_13
    end
  end

  // Output drive
  assign pc_out = pc_q;
  assign instr_valid_out = rd_fetch_q;
  assign instr_out = mem_rdata;
  assign tbl_busy_out = (state_q == pmtr_pkg::TBL_BUSY);
  assign dest_wr_valid_out = dest_valid_q;
  assign dest_wr_out = dest_q;
  assign table_high_latch_out = latch_q;
  assign debug_serial_data_pin_out = dbg_out_q;
  assign debug_serial_data_pin_oe_n_out = dbg_oe_n_q;
  assign dbg_rx_out = dbg_rx_q;
  assign dbg_clk_out = dbg_clk_q;
  assign func_data_view_out = fview_q;
  assign func_clk_view_out = fclk_q;

  // Checks
  localparam int A_TBL_LAT = pmtr_pkg::TBL_CLKS - 1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_reset_vector: assert property (@(posedge clk_in) disable iff (1'b0) // RULE_02
    rst_in |=> pc_out == pmtr_pkg::RESET_VECTOR) else $error("PC not at reset vector");
  a_fetch_step: assert property (fetch_go && !pc_load_in |=> pc_out == $past(pc_out) + 1'b1) // RULE_01
    else $error("PC did not step on fetch");
  a_tbl_latency: assert property (tbl_go |-> ##A_TBL_LAT dest_wr_valid_out) // RULE_10
    else $error("Table read not done in two instruction cycles");
  a_tbl_no_early: assert property (tbl_go |=> !dest_wr_valid_out [*6]) // RULE_10
    else $error("Table read finished early");
  a_full_pointer: assert property (tbl_go && !tbl_req_in.last_page |-> // RULE_04
    mem_addr == {tbhp_in[ADDR_W-9:0], tblp_in}) else $error("Bad full pointer address");
  a_last_page: assert property (tbl_go && tbl_req_in.last_page |-> // RULE_14
    mem_addr[ADDR_W-1:8] == '1 && mem_addr[7:0] == tblp_in) else $error("Bad last page address");
  a_low_to_dest: assert property (rd_tbl_q |-> ##6 dest_wr_out.data == $past(rd_low_w, 6)) // RULE_06
    else $error("Low byte not written to destination");
  a_high_latch: assert property (rd_tbl_q |-> ##6 table_high_latch_out == $past(rd_high_w, 6)) // RULE_07
    else $error("High part not loaded into latch");
  a_latch_only_tbl: assert property (!$stable(table_high_latch_out) |-> dest_wr_valid_out) // RULE_09
    else $error("Latch changed outside a table read");
  a_debug_isolate: assert property (EV_VARIANT |-> !func_data_view_out && !func_clk_view_out) // RULE_13
    else $error("Shared function sees debug pins on emulation variant");
  a_prog_owns: assert property (prog_mode_in |-> !tbl_ready_out && !fetch_ready_out) // RULE_12
    else $error("Core access during programming");

  c_tbl_full: cover property (tbl_go && !tbl_req_in.last_page ##7 dest_wr_valid_out);
  c_tbl_last: cover property (tbl_go && tbl_req_in.last_page ##7 dest_wr_valid_out);
  c_prog_write: cover property (mem_we);
  c_prog_read: cover property (prog_rd_dly_q);

endmodule

//--- verif/pmtr_core_model.sv
// Processor core model that issues instruction fetches and table reads.
// Assumes it shares clk_in with the block and drives every request just after a rising edge.
`timescale 1ns/10ps
module pmtr_core_model (
  input wire logic clk_in,
  input wire logic fetch_ready_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic tbl_ready_in,
  input wire logic dest_wr_valid_in,
  input wire pmtr_pkg::pmtr_dest_wr_type dest_wr_in,
  input wire logic [7:0] table_high_latch_in,
  output logic pc_load_out,
  output logic [10:0] pc_target_out,
  output logic fetch_req_out,
  output logic [7:0] tblp_out,
  output logic [7:0] tbhp_out,
  output logic tbl_start_out,
  output pmtr_pkg::pmtr_tbl_req_type tbl_req_out
);
  // Idle requests from time zero
  initial begin
    pc_load_out = 1'b0;
    pc_target_out = 11'h000;
    fetch_req_out = 1'b0;
    tblp_out = 8'h00;
    tbhp_out = 8'h00;
    tbl_start_out = 1'b0;
    tbl_req_out = '0;
  end

  // One fetch, optionally after a jump; the request is held until ready is seen high
  task automatic fetch(input logic load, input logic [10:0] tgt, output logic [15:0] word,
                       output logic ok);
    if (load) begin
      @(posedge clk_in);
      pc_load_out <= 1'b1;
      pc_target_out <= tgt;
    end
    @(posedge clk_in);
    pc_load_out <= 1'b0;
    fetch_req_out <= 1'b1;
    @(posedge clk_in);
    while (fetch_ready_in !== 1'b1) @(posedge clk_in);
    fetch_req_out <= 1'b0;
    #1;
    ok = instr_valid_in;
    word = instr_in;
  endtask

  // One table read; the next is issued only after this one has written back
  // Poke raises a second start while busy, which the block must ignore
  task automatic tbl_read(input logic lp, input logic [7:0] hp, input logic [7:0] lo,
                          input logic [7:0] dst, input bit poke, output int k,
                          output logic [7:0] data, output logic [7:0] da,
                          output logic [7:0] hi, output logic extra);
    @(posedge clk_in);
    tbhp_out <= hp;
    tblp_out <= lo;
    tbl_req_out <= '{last_page: lp, dest: dst};
    tbl_start_out <= 1'b1;
    @(posedge clk_in);
    while (tbl_ready_in !== 1'b1) @(posedge clk_in);
    tbl_start_out <= 1'b0;
    k = 1;
    while (k < 20) begin
      #1;
      if (dest_wr_valid_in === 1'b1) break;
      @(posedge clk_in);
      k++;
      if (poke && k == 2) begin
        tbl_start_out <= 1'b1;
        tbl_req_out <= '{last_page: ~lp, dest: ~dst};
      end
      if (poke && k == 4) tbl_start_out <= 1'b0;
    end
    data = dest_wr_in.data;
    da = dest_wr_in.addr;
    hi = table_high_latch_in;
    @(posedge clk_in);
    #1;
    extra = dest_wr_valid_in;
  endtask
endmodule

//--- verif/tb_pmtr_top.sv
// Self-checking bench of the program memory read path with a core model on the far side.
// Assumes the code store array is reachable as uut.u_store.mem_q for preloading.
`timescale 1ns/10ps
module tb_pmtr_top;
  logic clk_in, rst_in, prog_mode_in, prog_ck, dbg_ck, dbg_tx, dbg_tx_en, func_data, func_oe_n;
  logic pc_load, fetch_req, tbl_start, fetch_ready, instr_valid, tbl_ready, tbl_busy, dwv;
  logic [10:0] pc_target, pc;
  logic [7:0] tblp, tbhp, latch;
  logic [15:0] instr;
  logic pda_out, pda_oe_n, dda_out, dda_oe_n, rx, dck, fdv, fcv;
  logic prog_da, prog_oe_n, ev_out, ev_oe_n, ev_rx, ev_ck, ev_fdv, ev_fcv;
  pmtr_pkg::pmtr_tbl_req_type tbl_req;
  pmtr_pkg::pmtr_dest_wr_type dw;
  logic [15:0] exp_mem [0:2047];
  int error_cnt = 0;
  int check_count = 0;
  // Data pins carry a pull-up when nobody drives them
  wire pda_pin = !pda_oe_n ? pda_out : (prog_oe_n ? 1'b1 : prog_da);
  wire dda_pin = dda_oe_n ? 1'b1 : dda_out;
  wire ev_pin = ev_oe_n ? 1'b1 : ev_out;

  // Clock at 25 MHz
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  pmtr_top #(.ADDR_W(11), .WORD_W(16), .EV_VARIANT(1'b0)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .pc_load_in(pc_load), .pc_target_in(pc_target),
    .fetch_req_in(fetch_req), .fetch_ready_out(fetch_ready), .pc_out(pc),
    .instr_valid_out(instr_valid), .instr_out(instr), .tblp_in(tblp), .tbhp_in(tbhp),
    .tbl_start_in(tbl_start), .tbl_req_in(tbl_req), .tbl_ready_out(tbl_ready),
    .tbl_busy_out(tbl_busy), .dest_wr_valid_out(dwv), .dest_wr_out(dw),
    .table_high_latch_out(latch), .prog_mode_in(prog_mode_in),
    .prog_serial_clock_pin_in(prog_ck), .prog_serial_data_pin_in(pda_pin),
    .prog_serial_data_pin_out(pda_out), .prog_serial_data_pin_oe_n_out(pda_oe_n),
    .debug_serial_clock_pin_in(dbg_ck), .debug_serial_data_pin_in(dda_pin),
    .debug_serial_data_pin_out(dda_out), .debug_serial_data_pin_oe_n_out(dda_oe_n),
    .dbg_tx_in(dbg_tx), .dbg_tx_en_in(dbg_tx_en), .dbg_rx_out(rx), .dbg_clk_out(dck),
    .func_data_in(func_data), .func_oe_n_in(func_oe_n), .func_data_view_out(fdv),
    .func_clk_view_out(fcv));

  // Emulation variant: only its debug pins are exercised
  pmtr_top #(.ADDR_W(11), .WORD_W(16), .EV_VARIANT(1'b1)) uut_ev (
    .clk_in(clk_in), .rst_in(rst_in), .pc_load_in(1'b0), .pc_target_in(11'h000),
    .fetch_req_in(1'b0), .fetch_ready_out(), .pc_out(), .instr_valid_out(), .instr_out(),
    .tblp_in(8'h00), .tbhp_in(8'h00), .tbl_start_in(1'b0), .tbl_req_in('0),
    .tbl_ready_out(), .tbl_busy_out(), .dest_wr_valid_out(), .dest_wr_out(),
    .table_high_latch_out(), .prog_mode_in(1'b0), .prog_serial_clock_pin_in(1'b0),
    .prog_serial_data_pin_in(1'b1), .prog_serial_data_pin_out(),
    .prog_serial_data_pin_oe_n_out(), .debug_serial_clock_pin_in(dbg_ck),
    .debug_serial_data_pin_in(ev_pin), .debug_serial_data_pin_out(ev_out),
    .debug_serial_data_pin_oe_n_out(ev_oe_n), .dbg_tx_in(dbg_tx), .dbg_tx_en_in(dbg_tx_en),
    .dbg_rx_out(ev_rx), .dbg_clk_out(ev_ck), .func_data_in(func_data),
    .func_oe_n_in(func_oe_n), .func_data_view_out(ev_fdv), .func_clk_view_out(ev_fcv));

  pmtr_core_model u_core (
    .clk_in(clk_in), .fetch_ready_in(fetch_ready), .instr_valid_in(instr_valid),
    .instr_in(instr), .tbl_ready_in(tbl_ready), .dest_wr_valid_in(dwv), .dest_wr_in(dw),
    .table_high_latch_in(latch), .pc_load_out(pc_load), .pc_target_out(pc_target),
    .fetch_req_out(fetch_req), .tblp_out(tblp), .tbhp_out(tbhp), .tbl_start_out(tbl_start),
    .tbl_req_out(tbl_req));

  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Preload a word through the back door and keep a shadow copy
  task automatic preload(input logic [10:0] a, input logic [15:0] v);
    uut.u_store.mem_q[a] = v;
    exp_mem[a] = v;
  endtask

  // Reset pulse of a given length, then the reset state
  task automatic t_reset(input int n);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (n) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    check(pc, 11'h000);
    check(dwv, 1'b0);
    check(latch, 8'h00);
  endtask

  // Programmer frame, MSB first; read bits are taken as the programmer clock rises
  task automatic prog_frame(input logic wr, input logic [10:0] a, input logic [15:0] v,
                            output logic [15:0] rd);
    logic [27:0] f;
    f = {wr, a, v};
    rd = 16'h0000;
    @(posedge clk_in);
    for (int b = 27; b >= 0; b--) begin
      prog_da <= f[b];
      prog_oe_n <= !wr && b < 16;
      repeat (2) @(posedge clk_in);
      if (b < 16) rd[b] = pda_pin;
      prog_ck <= 1'b1;
      repeat (2) @(posedge clk_in);
      prog_ck <= 1'b0;
    end
    prog_oe_n <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask

  // Sequential fetch from the reset vector, then a jump to the top word
  task automatic t_fetch();
    logic [15:0] w;
    logic ok;
    u_core.fetch(1'b0, 11'h000, w, ok);
    check(ok, 1'b1);
    check(w, exp_mem[11'h000]);
    check(pc, 11'h001);
    u_core.fetch(1'b1, 11'h7FF, w, ok);
    check(w, exp_mem[11'h7FF]);
    check(pc, 11'h000);
  endtask

  // Table reads over both forms, page edges and ignored pointer bits
  task automatic t_table();
    logic lp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [7:0] hp [5] = '{8'h01, 8'h00, 8'hFB, 8'h00, 8'h07};
    logic [7:0] lo [5] = '{8'h06, 8'h05, 8'h06, 8'h00, 8'hFF};
    logic [10:0] ea [5] = '{11'h706, 11'h705, 11'h306, 11'h000, 11'h7FF};
    int k;
    logic [7:0] d, da, hi;
    logic x;
    for (int i = 0; i < 5; i++) begin
      u_core.tbl_read(lp[i], hp[i], lo[i], 8'h80 + 8'(i), i == 2, k, d, da, hi, x);
      check(k, 7);
      check(d, exp_mem[ea[i]][7:0]);
      check(da, 8'h80 + 8'(i));
      check(hi, exp_mem[ea[i]][15:8]);
      check(x, 1'b0);
    end
  endtask

  // The latch keeps the last table value across fetches of other words
  task automatic t_latch_hold();
    logic [15:0] w;
    logic ok;
    u_core.fetch(1'b1, 11'h306, w, ok);
    u_core.fetch(1'b0, 11'h000, w, ok);
    check(latch, exp_mem[11'h7FF][15:8]);
  endtask

  // Shared functions keep the debug pins and the debug link stays dark, except on the emulation variant where the link has them
  task automatic t_debug_pins();
    @(posedge clk_in);
    func_oe_n <= 1'b0;
    func_data <= 1'b1;
    dbg_ck <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check({dda_oe_n, dda_out, fdv, fcv}, 4'b0111);
    check({rx, dck}, 2'b00);
    check({ev_oe_n, ev_out, ev_rx, ev_ck, ev_fdv, ev_fcv}, 6'b101100);
    @(posedge clk_in);
    func_data <= 1'b0;
    dbg_ck <= 1'b0;
    dbg_tx <= 1'b1;
    dbg_tx_en <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check({dda_oe_n, dda_out, fdv, fcv}, 4'b0000);
    check({ev_oe_n, ev_out, ev_rx, ev_ck, ev_fdv, ev_fcv}, 6'b011000);
  endtask

  // Programming mode takes the store away from the core
  task automatic t_prog_mode();
    logic [15:0] r;
    @(posedge clk_in);
    prog_mode_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check({fetch_ready, tbl_ready}, 2'b00);
    check(pda_oe_n, 1'b1);
    prog_frame(1'b1, 11'h123, 16'h3C5A, r);
    prog_frame(1'b0, 11'h123, 16'h0000, r);
    check(r, 16'h3C5A);
    prog_frame(1'b0, 11'h7FF, 16'h0000, r);
    check(r, exp_mem[11'h7FF]);
    check(pda_oe_n, 1'b1);
    @(posedge clk_in);
    prog_mode_in <= 1'b0;
    #1;
    check({fetch_ready, tbl_ready}, 2'b11);
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge clk_in);
    error_cnt++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst_in = 1'b1;
    prog_mode_in = 1'b0;
    prog_ck = 1'b0;
    prog_da = 1'b1;
    prog_oe_n = 1'b1;
    dbg_ck = 1'b0;
    dbg_tx = 1'b0;
    dbg_tx_en = 1'b0;
    func_data = 1'b0;
    func_oe_n = 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    check(pc, 11'h000);
    check(latch, 8'h00);
    preload(11'h000, 16'h1234);
    preload(11'h7FF, 16'hBEEF);
    preload(11'h306, 16'h5AC3);
    preload(11'h706, 16'h001A);
    preload(11'h705, 16'h000F);
    t_fetch();
    t_table();
    t_latch_hold();
    t_debug_pins();
    t_prog_mode();
    t_reset(2);
    print_verdict();
  end
endmodule
